// file: rtl/fcache_data_ram.sv
`timescale 1ns/1ps
module fcache_data_ram
    import fcache_pkg::*;
(
    // Clock
    input  wire logic mclk,
    // Array port
    fcache_wr_if.mem  port
);
    logic [63:0] mem_q [FC_ROWS*FC_QUADS];
    logic [63:0] rd_q;

    // Synchronous read; the array holds no reset so it maps onto memory
    always_ff @(posedge mclk) begin
        if (port.we) begin
            mem_q[{port.row, port.quad}] <= port.wdata;
        end
        rd_q <= mem_q[{port.row, port.quad}];
    end

    assign port.rdata = rd_q;
endmodule // fcache_data_ram

// file: rtl/fcache_ipr.sv
`timescale 1ns/1ps
module fcache_ipr
    import fcache_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Processor-register access
    input  wire logic        ipr_rd,
    input  wire logic        ipr_wr,
    input  wire logic [1:0]  ipr_sel,
    input  wire logic [31:0] memory_return_bus,
    input  wire logic        ipr_write_done,
    output logic      [31:0] ipr_read_return_bus,
    // Lookup side
    input  wire logic        lookup_req,
    input  wire logic [31:0] fetch_lookup_addr,
    input  wire logic        prefetch_queue_full,
    input  wire logic        fill_pending,
    input  wire logic        lookup_hit,
    input  wire logic        tag_parity_fault,
    input  wire logic        data_parity_fault,
    // Control and performance
    output logic             fetch_cache_on,
    output logic             perf_access_strobe,
    output logic             perf_hit_flag
);
    fcache_wr_if arr ();

    logic [31:0] idx_q, idx_d;
    logic [31:0] tag_q [FC_ROWS];
    logic [31:0] fill_lo_q, fill_lo_d;
    logic [31:0] hi_q, hi_d;
    logic        en_q, en_d;
    logic        lock_q, lock_d;
    logic        dpe_q, dpe_d;
    logic        tpe_q, tpe_d;
    logic [31:0] rbus_q, rbus_d;
    logic        acc_q, acc_d;
    logic        hit_q, hit_d;
    logic        seen_q, seen_d;
    fcache_acc_t st_q, st_d;
    logic        wr_now;
    logic        fault;
    logic [5:0]  row;
    logic [1:0]  quad;
    logic        wpick;

    fcache_data_ram u_ram (
        .mclk (mclk),
        .port (arr.mem)
    );

    assign row    = idx_q[FC_ROW_HI:FC_ROW_LO];
    assign quad   = idx_q[FC_QUAD_HI:FC_QUAD_LO];
    assign wpick  = idx_q[FC_WPICK_BIT];
    assign wr_now = ipr_wr & ipr_write_done;
    assign fault  = en_q & lookup_req & (tag_parity_fault | data_parity_fault);

    // Direct array access only while disabled; lookup side owns the array otherwise
    assign arr.row   = en_q ? fetch_lookup_addr[FC_ROW_HI:FC_ROW_LO] : row;
    assign arr.quad  = en_q ? fetch_lookup_addr[FC_QUAD_HI:FC_QUAD_LO] : quad;
    assign arr.we    = wr_now & ~en_q & (ipr_sel == FC_REG_DATA) & wpick;
    assign arr.wdata = {memory_return_bus, fill_lo_q};

    always_comb begin
        idx_d     = idx_q;
        fill_lo_d = fill_lo_q;
        hi_d      = hi_q;
        en_d      = en_q;
        lock_d    = lock_q;
        dpe_d     = dpe_q;
        tpe_d     = tpe_q;
        rbus_d    = rbus_q;
        st_d      = st_q;
        if (wr_now) begin
            if (ipr_sel == FC_REG_INDEX) begin
                // Tag field is read-only, only index fields take the write
                idx_d[FC_ROW_HI:FC_WPICK_BIT] = memory_return_bus[FC_ROW_HI:FC_WPICK_BIT];
            end else if (ipr_sel == FC_REG_DATA) begin
                if (!wpick) begin
                    fill_lo_d = memory_return_bus;
                end
            end else if (ipr_sel == FC_REG_CSR) begin
                en_d = memory_return_bus[FC_EN_BIT];
                if (memory_return_bus[FC_LOCK_BIT]) begin
                    lock_d = 1'b0;
                end
            end
        end
        // A fault in the same cycle as the clearing write still wins
        if (fault && !lock_d) begin
            lock_d = 1'b1;
            dpe_d  = data_parity_fault;
            tpe_d  = tag_parity_fault & ~data_parity_fault;
            idx_d[FC_TAG_HI:FC_TAG_LO]   = fetch_lookup_addr[FC_TAG_HI:FC_TAG_LO];
            idx_d[FC_ROW_HI:FC_QUAD_LO]  = fetch_lookup_addr[FC_ROW_HI:FC_QUAD_LO];
        end
        case (st_q)
            FC_ACC_IDLE: begin
                if (ipr_rd && ipr_sel == FC_REG_DATA && !wpick) begin
                    st_d = FC_ACC_WAIT;
                end
            end
            FC_ACC_WAIT: begin
                hi_d   = arr.rdata[63:32];
                rbus_d = arr.rdata[31:0];
                st_d   = FC_ACC_IDLE;
            end
            default: st_d = FC_ACC_IDLE;
        endcase
        if (ipr_rd) begin
            if (ipr_sel == FC_REG_INDEX) begin
                rbus_d = idx_q & 32'hFFFF_FFF8;
            end else if (ipr_sel == FC_REG_TAG) begin
                rbus_d = tag_q[row];
            end else if (ipr_sel == FC_REG_DATA) begin
                if (wpick) begin
                    rbus_d = hi_q;
                end
            end else begin
                rbus_d = {27'h0000000, tpe_q, dpe_q, lock_q, 1'b0, en_q};
            end
        end
    end

    // Perf: first attempt of each reference only, while queue can take it
    always_comb begin
        acc_d  = 1'b0;
        hit_d  = 1'b0;
        seen_d = seen_q;
        if (!(en_q && lookup_req)) begin
            seen_d = 1'b0;
        end else if (!seen_q && !prefetch_queue_full && !fill_pending) begin
            acc_d  = 1'b1;
            hit_d  = lookup_hit;
            seen_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q     <= FC_WORD_RST;
            fill_lo_q <= FC_WORD_RST;
            hi_q      <= FC_WORD_RST;
            en_q      <= FC_EN_RST;
            lock_q    <= 1'b0;
            dpe_q     <= 1'b0;
            tpe_q     <= 1'b0;
            rbus_q    <= FC_WORD_RST;
            st_q      <= FC_ACC_IDLE;
            acc_q     <= 1'b0;
            hit_q     <= 1'b0;
            seen_q    <= 1'b0;
        end else begin
            idx_q     <= idx_d;
            fill_lo_q <= fill_lo_d;
            hi_q      <= hi_d;
            en_q      <= en_d;
            lock_q    <= lock_d;
            dpe_q     <= dpe_d;
            tpe_q     <= tpe_d;
            rbus_q    <= rbus_d;
            st_q      <= st_d;
            acc_q     <= acc_d;
            hit_q     <= hit_d;
            seen_q    <= seen_d;
        end
    end

    // Tag array with no reset so it can map onto memory; valid bits undefined until written
    always_ff @(posedge mclk) begin
        if (wr_now && !en_q && ipr_sel == FC_REG_TAG) begin
            tag_q[row] <= memory_return_bus & 32'hFFFF_F9FF;
        end
    end

    assign ipr_read_return_bus = rbus_q;
    assign fetch_cache_on      = en_q;
    assign perf_access_strobe  = acc_q;
    assign perf_hit_flag       = hit_q;

    lock_sets_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (fault && !lock_q)
        |=> lock_q)
        else $error("lock not set on fault");

    lock_freeze_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (lock_q && !(wr_now && ipr_sel == FC_REG_CSR))
        |=> $stable(dpe_q) && $stable(tpe_q))
        else $error("status moved while locked");

    one_type_a: assert property (@(posedge mclk) disable iff (!rst_n)
        lock_q
        |-> (dpe_q ^ tpe_q))
        else $error("error type not unique");

    lock_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_now && ipr_sel == FC_REG_CSR && memory_return_bus[FC_LOCK_BIT] && !fault)
        |=> !lock_q)
        else $error("lock not cleared");

    enable_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_now && ipr_sel == FC_REG_CSR)
        |=> en_q == $past(memory_return_bus[FC_EN_BIT]))
        else $error("enable not written");

    perf_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
        perf_access_strobe
        |=> !perf_access_strobe)
        else $error("repeat access count");

    hit_pair_a: assert property (@(posedge mclk) disable iff (!rst_n)
        perf_hit_flag
        |-> perf_access_strobe)
        else $error("hit without access");

    low_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_q == FC_ACC_IDLE && ipr_rd && ipr_sel == FC_REG_DATA && !wpick)
        |=> ##1 ipr_read_return_bus == $past(arr.rdata[31:0]))
        else $error("low word not returned");

    no_arr_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        en_q
        |-> !arr.we)
        else $error("array written while enabled");

    idx_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_now && ipr_sel == FC_REG_INDEX && !fault)
        |=> idx_q[FC_ROW_HI:FC_WPICK_BIT] == $past(memory_return_bus[FC_ROW_HI:FC_WPICK_BIT]))
        else $error("index fields not written");

    idx_tag_ro_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_now && ipr_sel == FC_REG_INDEX && !fault)
        |=> $stable(idx_q[FC_TAG_HI:FC_TAG_LO]))
        else $error("read-only address field written");

    err_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (fault && !lock_q)
        |=> idx_q[FC_TAG_HI:FC_QUAD_LO] == $past(fetch_lookup_addr[FC_TAG_HI:FC_QUAD_LO]))
        else $error("fault address not captured");

    addr_freeze_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (lock_q && !wr_now)
        |=> $stable(idx_q))
        else $error("error address moved while locked");

    data_first_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (fault && !lock_q && data_parity_fault)
        |=> dpe_q && !tpe_q)
        else $error("data error not reported first");

    lock_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!lock_q && !fault)
        |=> !lock_q)
        else $error("lock set without fault");

    tag_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_now && !en_q && ipr_sel == FC_REG_TAG)
        |=> tag_q[$past(row)] == ($past(memory_return_bus) & 32'hFFFF_F9FF))
        else $error("tag row not written");

    fill_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_now && ipr_sel == FC_REG_DATA && !wpick)
        |=> fill_lo_q == $past(memory_return_bus))
        else $error("fill low half not loaded");

    low_no_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_now && ipr_sel == FC_REG_DATA && !wpick)
        |-> !arr.we)
        else $error("array written on low half");

    quad_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_now && !en_q && ipr_sel == FC_REG_DATA && wpick)
        |-> arr.we && arr.wdata == {memory_return_bus, fill_lo_q})
        else $error("quadword not written");

    fill_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_now && ipr_sel == FC_REG_DATA && wpick)
        |=> $stable(fill_lo_q))
        else $error("fill low half lost");

    hi_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_q == FC_ACC_WAIT)
        |=> hi_q == $past(arr.rdata[63:32]))
        else $error("high word not latched");

    hi_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_q == FC_ACC_IDLE && ipr_rd && ipr_sel == FC_REG_DATA && wpick)
        |=> ipr_read_return_bus == $past(hi_q))
        else $error("high word not returned");

    csr_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ipr_rd && ipr_sel == FC_REG_CSR)
        |=> ipr_read_return_bus[FC_LOCK_BIT:FC_EN_BIT] == {$past(lock_q), 1'b0, $past(en_q)})
        else $error("control read wrong");

    en_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !(wr_now && ipr_sel == FC_REG_CSR)
        |=> $stable(en_q))
        else $error("enable moved without write");

    rd_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!ipr_rd && st_q == FC_ACC_IDLE)
        |=> $stable(ipr_read_return_bus))
        else $error("read bus moved without read");

    perf_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        perf_access_strobe
        |-> $past(en_q && lookup_req && !prefetch_queue_full && !fill_pending))
        else $error("access counted without usable reference");

    perf_busy_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (prefetch_queue_full || fill_pending)
        |=> !perf_access_strobe)
        else $error("access counted while busy");

    hit_value_a: assert property (@(posedge mclk) disable iff (!rst_n)
        perf_access_strobe
        |-> perf_hit_flag == $past(lookup_hit))
        else $error("hit flag wrong");

    fault_c: cover property (@(posedge mclk) disable iff (!rst_n) fault ##1 lock_q);
    perf_c: cover property (@(posedge mclk) disable iff (!rst_n) perf_hit_flag);
    quad_wr_c: cover property (@(posedge mclk) disable iff (!rst_n) arr.we);
    lock_clr_c: cover property (@(posedge mclk) disable iff (!rst_n) lock_q ##1 !lock_q);
    low_read_c: cover property (@(posedge mclk) disable iff (!rst_n) st_q == FC_ACC_WAIT);
endmodule // fcache_ipr

// file: rtl/fcache_pkg.sv
package fcache_pkg;
    localparam int unsigned FC_ROWS      = 64;
    localparam int unsigned FC_ROW_W     = 6;
    localparam int unsigned FC_TAG_W     = 21;
    localparam int unsigned FC_QUADS     = 4;
    localparam int unsigned FC_SEL_W     = 2;
    // Register numbers on the processor-register select
    localparam logic [1:0] FC_REG_INDEX  = 2'h0;
    localparam logic [1:0] FC_REG_TAG    = 2'h1;
    localparam logic [1:0] FC_REG_DATA   = 2'h2;
    localparam logic [1:0] FC_REG_CSR    = 2'h3;
    // Field positions
    localparam int unsigned FC_WPICK_BIT = 2;
    localparam int unsigned FC_QUAD_LO   = 3;
    localparam int unsigned FC_QUAD_HI   = 4;
    localparam int unsigned FC_ROW_LO    = 5;
    localparam int unsigned FC_ROW_HI    = 10;
    localparam int unsigned FC_TAG_LO    = 11;
    localparam int unsigned FC_TAG_HI    = 31;
    localparam int unsigned FC_VAL_LO    = 0;
    localparam int unsigned FC_VAL_HI    = 3;
    localparam int unsigned FC_DP_LO     = 4;
    localparam int unsigned FC_DP_HI     = 7;
    localparam int unsigned FC_TP_BIT    = 8;
    localparam int unsigned FC_EN_BIT    = 0;
    localparam int unsigned FC_LOCK_BIT  = 2;
    localparam int unsigned FC_DPE_BIT   = 3;
    localparam int unsigned FC_TPE_BIT   = 4;
    // Reset values and read latency
    localparam logic        FC_EN_RST    = 1'b0;
    localparam logic [31:0] FC_WORD_RST  = 32'h0000_0000;
    localparam int unsigned FC_RD_LAT    = 1;
    typedef enum logic [1:0] {
        FC_ACC_IDLE = 2'b00,
        FC_ACC_WAIT = 2'b01
    } fcache_acc_t;
endpackage

// file: rtl/fcache_wr_if.sv
`timescale 1ns/1ps
interface fcache_wr_if;
    logic                    we;
    logic [5:0]              row;
    logic [1:0]              quad;
    logic [63:0]             wdata;
    logic [63:0]             rdata;
    modport ctrl (output we, output row, output quad, output wdata, input rdata);
    modport mem  (input we, input row, input quad, input wdata, output rdata);
endinterface

// file: tb/fcache_mem_model.sv
`timescale 1ns/1ps
module fcache_mem_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Request from the bench
    input  wire logic        go,
    input  wire logic [31:0] data,
    input  wire logic [2:0]  wait_cyc,
    // Return side
    output logic             ipr_write_done,
    output logic [31:0]      memory_return_bus
);
    logic [3:0]  cnt_q;
    logic [31:0] hold_q;
    // Idle bus toggles every cycle, so a late sample never passes for data
    always @(negedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            hold_q <= 32'h0;
            ipr_write_done <= 1'h0;
            memory_return_bus <= 32'h0;
        end else begin
            ipr_write_done <= 1'h0;
            memory_return_bus <= ~memory_return_bus;
            if (go) begin
                cnt_q <= {1'h0, wait_cyc} + 4'h1;
                hold_q <= data;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    ipr_write_done <= 1'h1;
                    memory_return_bus <= hold_q;
                end
            end
        end
    end
endmodule // fcache_mem_model

// file: tb/tb_icache_ipr_access_errlog.sv
`timescale 1ns/1ps
module tb_icache_ipr_access_errlog;
    import fcache_pkg::*;
    logic        mclk, rst_n, ipr_rd, ipr_wr, go, lookup_req, lookup_hit;
    logic        prefetch_queue_full, fill_pending, tag_parity_fault, data_parity_fault;
    logic        ipr_write_done, fetch_cache_on, perf_access_strobe, perf_hit_flag;
    logic [1:0]  ipr_sel;
    logic [2:0]  pwait;
    logic [31:0] memory_return_bus, ipr_read_return_bus, fetch_lookup_addr, pdata, v, a;
    logic [31:0] tv [4], lo [4], hi [4];
    logic [5:0]  rw [4], r;
    int          errors, tests_run, cyc;

    fcache_ipr DUT (.mclk, .rst_n, .ipr_rd, .ipr_wr, .ipr_sel, .memory_return_bus,
        .ipr_write_done, .ipr_read_return_bus, .lookup_req, .fetch_lookup_addr,
        .prefetch_queue_full, .fill_pending, .lookup_hit, .tag_parity_fault,
        .data_parity_fault, .fetch_cache_on, .perf_access_strobe, .perf_hit_flag);
    fcache_mem_model u_mem (.mclk, .rst_n, .go, .data(pdata), .wait_cyc(pwait),
        .ipr_write_done, .memory_return_bus);

    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end

    function automatic logic [31:0] ix(input logic [5:0] rr, input logic [1:0] q,
                                       input logic p);
        return {21'h0, rr, q, p, 2'h0};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until the edge that sees the completion strobe
    task automatic wr(input logic [1:0] s, input logic [31:0] d);
        int k;
        ipr_wr <= 1'h1;
        ipr_sel <= s;
        go <= 1'h1;
        pdata <= d;
        pwait <= 3'($urandom % 4);
        @(negedge mclk) go <= 1'h0;
        for (k = 0; k < 20; k++) begin
            @(posedge mclk);
            if (ipr_write_done === 1'h1) break;
        end
        @(negedge mclk) ipr_wr <= 1'h0;
        // One idle edge so back-to-back calls never drive the strobe twice at once
        @(negedge mclk);
    endtask

    task automatic rd(input logic [1:0] s, input int lat, output logic [31:0] d);
        ipr_rd <= 1'h1;
        ipr_sel <= s;
        @(negedge mclk) ipr_rd <= 1'h0;
        repeat (lat) @(negedge mclk);
        d = ipr_read_return_bus;
    endtask

    task automatic perf(input logic f, input logic p, input logic h);
        lookup_req <= 1'h1;
        prefetch_queue_full <= f;
        fill_pending <= p;
        lookup_hit <= h;
        @(negedge mclk);
        chk(perf_access_strobe, {31'h0, !f && !p});
        if (!f && !p) chk(perf_hit_flag, {31'h0, h});
        @(negedge mclk) chk(perf_access_strobe, 32'h0);
        lookup_req <= 1'h0;
        @(negedge mclk);
    endtask

    task automatic fault(input logic dp, input logic [31:0] ad);
        lookup_req <= 1'h1;
        fetch_lookup_addr <= ad;
        data_parity_fault <= dp;
        tag_parity_fault <= !dp;
        @(negedge mclk) lookup_req <= 1'h0;
        data_parity_fault <= 1'h0;
        tag_parity_fault <= 1'h0;
        @(negedge mclk);
    endtask

    task automatic give_verdict;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Run needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            give_verdict;
        end
    end

    initial begin
        {rst_n, ipr_rd, ipr_wr, go, lookup_req, lookup_hit, prefetch_queue_full} = 7'h0;
        {fill_pending, tag_parity_fault, data_parity_fault} = 3'h0;
        {ipr_sel, pwait, pdata, fetch_lookup_addr} = 69'h0;
        void'($urandom(32'h80B6));
        repeat (10) @(negedge mclk);
        rst_n <= 1'h1;
        @(negedge mclk) chk(fetch_cache_on, 32'h0);
        rd(FC_REG_CSR, 1, v);
        chk(v, 32'h0);
        // Cache stays off for all array access
        for (int i = 0; i < 4; i++) begin
            rw[i] = 6'(($urandom & 32'h3C) | i);
            tv[i] = $urandom;
            wr(FC_REG_INDEX, ix(rw[i], 2'h0, 1'h0));
            wr(FC_REG_TAG, tv[i]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(FC_REG_INDEX, ix(rw[i], 2'h0, 1'h0));
            rd(FC_REG_TAG, 1, v);
            chk(v, tv[i] & 32'hFFFF_F9FF);
        end
        r = 6'($urandom);
        for (int q = 0; q < 4; q++) begin
            lo[q] = $urandom;
            hi[q] = $urandom;
            wr(FC_REG_INDEX, ix(r, 2'(q), 1'h0));
            wr(FC_REG_DATA, lo[q]);
            wr(FC_REG_INDEX, ix(r, 2'(q), 1'h1));
            wr(FC_REG_DATA, hi[q]);
        end
        wr(FC_REG_INDEX, ix(r, 2'h0, 1'h0));
        wr(FC_REG_DATA, ~lo[0]);
        for (int q = 0; q < 4; q++) begin
            wr(FC_REG_INDEX, ix(r, 2'(q), 1'h0));
            rd(FC_REG_DATA, 2, v);
            chk(v, lo[q]);
            wr(FC_REG_INDEX, ix(r, 2'(q), 1'h1));
            rd(FC_REG_DATA, 1, v);
            chk(v, hi[q]);
        end
        rd(FC_REG_INDEX, 1, v);
        chk(v & 32'h7FF, ix(r, 2'h3, 1'h0));
        wr(FC_REG_CSR, 32'h1);
        chk(fetch_cache_on, 32'h1);
        for (int j = 0; j < 8; j++) perf(j[0], j[1], j[2]);
        a = $urandom;
        fault(1'h1, a);
        fault(1'h0, ~a);
        rd(FC_REG_CSR, 1, v);
        chk(v, 32'hD);
        rd(FC_REG_INDEX, 1, v);
        chk(v, a & 32'hFFFF_FFF8);
        wr(FC_REG_CSR, 32'h5);
        rd(FC_REG_CSR, 1, v);
        // Error type bits carry no meaning once the lock is clear
        chk(v & 32'h7, 32'h1);
        fault(1'h0, ~a);
        rd(FC_REG_CSR, 1, v);
        chk(v, 32'h15);
        rd(FC_REG_INDEX, 1, v);
        chk(v, ~a & 32'hFFFF_FFF8);
        give_verdict;
    end
endmodule // tb_icache_ipr_access_errlog
